// >>> multi_purpose_pin_mux.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

// Operation
// - thirty-two pins, each with its own independent select field
// - a pin serves an internal interface or the general port, per select
// - reset leaves all selects zero and every pin an undriven port input
// - pin n uses register n/8, bits 4*(n mod 8)+3 to 4*(n mod 8)
// - four select registers at 0xf000, 0xf004, 0xf008, 0xf00c, pins in order
// - code 0 joins pin n to general port bit n
// - code 2: memory grant, memory request or power event by position
// - code 3: end-of-transfer, index seven down to zero per pair
// - code 4: timer enable on even, terminal count on odd pins
// - code 5: burst or init-active indication by position in eight
// - code 6: active-low interrupt, index pin modulo four
// - code 7: PCI grant on even, request on odd pins, port table
// - code 9: watchdog outputs or baud clock in/out by position
// - codes 8 and 0xa to 0xe assign nothing
// - code 0xf drives debug bit n onto pin n
module multi_purpose_pin_mux
	import pin_mux_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// pins
	input  wire logic [31:0] pinLevel,
	output logic [31:0]      pinDrive,
	output logic [31:0]      pinDriveEn,
	// general port
	input  wire logic [31:0] portDriveValue,
	input  wire logic [31:0] portDriveEnable,
	output logic [31:0]      portSample,
	// dma
	output logic [7:0]       dmaRequestInN,
	input  wire logic [7:0]  dmaAcknowledgeOutN,
	output logic [7:0]       dmaEndOfTransfer,
	// shared memory and power management
	output logic             sharedMemoryGrantN,
	input  wire logic        sharedMemoryRequestN,
	input  wire logic        pmEventN,
	// timers
	output logic [7:0]       timerEnableIn,
	input  wire logic [7:0]  timerTerminalCountOut,
	// bus indications and interrupts
	input  wire logic        burstIndicationN,
	input  wire logic        initActiveIndication,
	input  wire logic [3:0]  intOutN,
	// pci arbiter
	input  wire logic [5:0]  pciGrantN,
	output logic [5:0]       pciRequestN,
	// watchdog and baud clocks
	input  wire logic        watchdogNmiOutN,
	input  wire logic        watchdogExpireOutN,
	output logic             baudClockIn,
	input  wire logic        baudClockOut,
	// debug
	input  wire logic [31:0] debugOut
);

	// ****************************************************************
	// constants
	// ****************************************************************
	localparam logic [15:0] GRANT_MASK   = `GRANT_MASK;
	localparam logic [15:0] SHARED_MEMORY_REQUEST_MASK    = `SHARED_MEMORY_REQUEST_MASK;
	localparam logic [15:0] PMEV_MASK    = `PMEV_MASK;
	localparam logic [15:0] WDOG_MASK    = `WDOG_MASK;
	localparam logic [15:0] BAUDIN_MASK  = `BAUDIN_MASK;
	localparam logic [15:0] BAUDOUT_MASK = `BAUDOUT_MASK;
	localparam logic [7:0]  BURST_MASK   = `BURST_MASK;
	localparam logic [23:0] PCI_MAP      = `PCI_PORT_MAP;

	// inactive levels for internal inputs with no pin routed to them
	localparam state_type RST_STATE = '{
		sel:       {4{`SEL_RESET}},
		wrPend:    1'b0,
		wrIdx:     2'h0,
		rdata:     32'h0000_0000,
		pinOut:    32'h0000_0000,
		pinOe:     32'h0000_0000,
		portIn:    32'h0000_0000,
		dmaReqN:   8'hff,
		memGrantN: 1'b1,
		xferEnd:   8'h00,
		tmrEn:     8'h00,
		pciReqN:   6'h3f,
		baudIn:    1'b0
	};

	// ****************************************************************
	// select decoding
	// ****************************************************************
	function automatic pin_fn_type pinKind(input int n, input logic [3:0] code);
		int   p16;
		int   p8;
		logic odd;
		p16 = n % 16;
		p8 = n % 8;
		odd = (n % 2) == 1;
		case (code)
			SEL_PORT: pinKind = FN_PORT;
			SEL_DMA: pinKind = odd ? FN_DMA_ACK : FN_DMA_REQ;
			SEL_MEMPM: begin
				if (GRANT_MASK[p16])
					pinKind = FN_MEM_GNT;
				else if (SHARED_MEMORY_REQUEST_MASK[p16])
					pinKind = FN_MEM_REQ;
				else if (PMEV_MASK[p16])
					pinKind = FN_PM_EVENT;
				else
					pinKind = FN_NONE;
			end
			SEL_XFER_END: pinKind = FN_END_XFER;
			SEL_TIMER: pinKind = odd ? FN_TMR_TC : FN_TMR_EN;
			SEL_BUS_IND: pinKind = BURST_MASK[p8] ? FN_BURST : FN_INIT;
			SEL_INT: pinKind = FN_INT;
			SEL_PCI_ARB: pinKind = odd ? FN_PCI_REQ : FN_PCI_GNT;
			SEL_WDOG_BAUD: begin
				if (WDOG_MASK[p16])
					pinKind = odd ? FN_WD_EXP : FN_WD_NMI;
				else if (BAUDIN_MASK[p16])
					pinKind = FN_BAUD_IN;
				else if (BAUDOUT_MASK[p16])
					pinKind = FN_BAUD_OUT;
				else
					pinKind = FN_NONE;
			end
			SEL_DEBUG: pinKind = FN_DEBUG;
			default: pinKind = FN_NONE;
		endcase
	endfunction

	function automatic logic [4:0] pinIndex(input int n, input logic [3:0] code);
		int pair;
		pair = (n % 16) / 2;
		case (code)
			SEL_DMA: pinIndex = 5'(pair);
			SEL_XFER_END: pinIndex = 5'(7 - pair);
			SEL_TIMER: pinIndex = (pair < 4) ? 5'(3 - pair) : 5'(11 - pair);
			SEL_INT: pinIndex = 5'(n % 4);
			SEL_PCI_ARB: pinIndex = {2'b00, PCI_MAP[3*pair +: 3]};
			default: pinIndex = 5'(n);
		endcase
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	state_type  cur_r;
	state_type  cur_nxt;
	pin_fn_type kind [32];
	logic [4:0] idx  [32];
	logic [3:0] selField [32];
	logic       aPhase;
	logic       aHit;
	logic [1:0] aIdx;

	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g++) begin : pinDecode
			assign selField[g] = cur_r.sel[g / `PINS_PER_REG][`SEL_WIDTH * (g % `PINS_PER_REG) +: `SEL_WIDTH];
			assign kind[g] = pinKind(g, selField[g]);
			assign idx[g] = pinIndex(g, selField[g]);
		end
	endgenerate

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign aPhase = hsel && hready && htrans[1];
	assign aHit = (haddr[15:4] == `SEL_BLOCK) && (haddr[1:0] == 2'b00) && (hsize == `HSIZE_WORD);
	assign aIdx = haddr[3:2];

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		cur_nxt = cur_r;
		// write lands at the end of its data phase
		if (cur_r.wrPend)
			cur_nxt.sel[cur_r.wrIdx] = hwdata;
		cur_nxt.wrPend = aPhase && hwrite && aHit;
		cur_nxt.wrIdx = aIdx;
		cur_nxt.rdata = 32'h0000_0000;
		// forward a write still in flight so back-to-back read sees it
		if (aPhase && !hwrite && aHit) begin
			if (cur_r.wrPend && (cur_r.wrIdx == aIdx))
				cur_nxt.rdata = hwdata;
			else
				cur_nxt.rdata = cur_r.sel[aIdx];
		end
		cur_nxt.pinOut = 32'h0000_0000;
		cur_nxt.pinOe = 32'h0000_0000;
		cur_nxt.portIn = 32'h0000_0000;
		cur_nxt.dmaReqN = 8'hff;
		cur_nxt.memGrantN = 1'b1;
		cur_nxt.xferEnd = 8'h00;
		cur_nxt.tmrEn = 8'h00;
		cur_nxt.pciReqN = 6'h3f;
		cur_nxt.baudIn = 1'b0;
		// several pins on one input are merged toward the active level
		for (int i = 0; i < `PIN_COUNT; i++) begin
			case (kind[i])
				FN_PORT: begin
					cur_nxt.pinOe[i] = portDriveEnable[i];
					cur_nxt.pinOut[i] = portDriveValue[i];
					cur_nxt.portIn[i] = pinLevel[i];
				end
				FN_DMA_REQ: cur_nxt.dmaReqN[idx[i][2:0]] = cur_nxt.dmaReqN[idx[i][2:0]] & pinLevel[i];
				FN_DMA_ACK: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = dmaAcknowledgeOutN[idx[i][2:0]];
				end
				FN_MEM_GNT: cur_nxt.memGrantN = cur_nxt.memGrantN & pinLevel[i];
				FN_MEM_REQ: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = sharedMemoryRequestN;
				end
				FN_PM_EVENT: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = pmEventN;
				end
				FN_END_XFER: cur_nxt.xferEnd[idx[i][2:0]] = cur_nxt.xferEnd[idx[i][2:0]] | pinLevel[i];
				FN_TMR_EN: cur_nxt.tmrEn[idx[i][2:0]] = cur_nxt.tmrEn[idx[i][2:0]] | pinLevel[i];
				FN_TMR_TC: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = timerTerminalCountOut[idx[i][2:0]];
				end
				FN_BURST: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = burstIndicationN;
				end
				FN_INIT: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = initActiveIndication;
				end
				FN_INT: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = intOutN[idx[i][1:0]];
				end
				FN_PCI_GNT: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = pciGrantN[idx[i][2:0]];
				end
				FN_PCI_REQ: cur_nxt.pciReqN[idx[i][2:0]] = cur_nxt.pciReqN[idx[i][2:0]] & pinLevel[i];
				FN_WD_NMI: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = watchdogNmiOutN;
				end
				FN_WD_EXP: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = watchdogExpireOutN;
				end
				FN_BAUD_IN: cur_nxt.baudIn = cur_nxt.baudIn | pinLevel[i];
				FN_BAUD_OUT: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = baudClockOut;
				end
				FN_DEBUG: begin
					cur_nxt.pinOe[i] = 1'b1;
					cur_nxt.pinOut[i] = debugOut[i];
				end
				default: begin
					cur_nxt.pinOe[i] = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			cur_r <= RST_STATE;
		else
			cur_r <= cur_nxt;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur_r.rdata;
	assign pinDrive = cur_r.pinOut;
	assign pinDriveEn = cur_r.pinOe;
	assign portSample = cur_r.portIn;
	assign dmaRequestInN = cur_r.dmaReqN;
	assign dmaEndOfTransfer = cur_r.xferEnd;
	assign sharedMemoryGrantN = cur_r.memGrantN;
	assign timerEnableIn = cur_r.tmrEn;
	assign pciRequestN = cur_r.pciReqN;
	assign baudClockIn = cur_r.baudIn;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	resetInput_a: assert property (disable iff (1'b0) sys_rst |=> (pinDriveEn == 32'h0) && (cur_r.sel == '0))
		else $error("pins not released to inputs after reset");

	selWrite_a: assert property (aPhase && hwrite && (haddr[15:0] == `SEL2_OFS) && (hsize == `HSIZE_WORD)
		|=> ##1 cur_r.sel[2] == $past(hwdata))
		else $error("select write did not land");

	readBack_a: assert property (aPhase && !hwrite && (haddr[15:0] == `SEL1_OFS) && (hsize == `HSIZE_WORD)
		&& !cur_r.wrPend |=> hrdata == $past(cur_r.sel[1]))
		else $error("select readback wrong");

	unmapped_a: assert property (aPhase && !hwrite && (haddr[15:4] != `SEL_BLOCK) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");

	dmaReqRoute_a: assert property ((selField[0] == SEL_DMA) && !pinLevel[0] |=> !dmaRequestInN[0])
		else $error("dma request not routed");

	memGrant_a: assert property ((selField[6] == SEL_MEMPM) && !pinLevel[6] |=> !sharedMemoryGrantN)
		else $error("memory grant not routed");

	xferEnd_a: assert property ((selField[0] == SEL_XFER_END) && pinLevel[0] |=> dmaEndOfTransfer[7])
		else $error("end of transfer index wrong");

	timerEn_a: assert property ((selField[0] == SEL_TIMER) && pinLevel[0] |=> timerEnableIn[3])
		else $error("timer enable index wrong");

	burstOut_a: assert property ((selField[3] == SEL_BUS_IND) |=> pinDriveEn[3] && pinDrive[3] == $past(burstIndicationN))
		else $error("burst indication not driven");

	pciGrant_a: assert property ((selField[12] == SEL_PCI_ARB) |=> pinDrive[12] == $past(pciGrantN[4]))
		else $error("pci grant port wrong");

	wdExpire_a: assert property ((selField[1] == SEL_WDOG_BAUD) |=> pinDrive[1] == $past(watchdogExpireOutN))
		else $error("watchdog expiry not driven");

	generate
		for (g = 0; g < `PIN_COUNT; g++) begin : pinCheck
			// skip the release edge: the flops still load the reset state there
			portDrive_a: assert property (!sys_rst && (selField[g] == SEL_PORT) |=>
				pinDriveEn[g] == $past(portDriveEnable[g]) && pinDrive[g] == $past(portDriveValue[g]))
				else $error("port bit not joined to pin");
			intDrive_a: assert property ((selField[g] == SEL_INT) |=> pinDrive[g] == $past(intOutN[g % 4]))
				else $error("interrupt index wrong");
			debugDrive_a: assert property ((selField[g] == SEL_DEBUG) |=> pinDriveEn[g] && pinDrive[g] == $past(debugOut[g]))
				else $error("debug bit not driven");
			reservedHiZ_a: assert property ((kind[g] == FN_NONE) |=> !pinDriveEn[g])
				else $error("reserved pin driven");
		end
	endgenerate

	writeSeen_c: cover property (cur_r.wrPend ##1 cur_r.sel[0] != `SEL_RESET);
	debugPin_c: cover property (kind[5] == FN_DEBUG ##1 pinDriveEn[5]);
	dmaRouted_c: cover property (kind[2] == FN_DMA_REQ && !pinLevel[2]);
	reservedPin_c: cover property (kind[3] == FN_NONE && selField[3] != SEL_PORT);

endmodule

// >>> pin_mux_regs.svh
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SEL0_OFS      16'hf000
`define SEL1_OFS      16'hf004
`define SEL2_OFS      16'hf008
`define SEL3_OFS      16'hf00c
`define SEL_BLOCK     12'hf00
`define SEL_RESET     32'h0000_0000
`define HSIZE_WORD    3'h2

// ****************************************************************
// select field layout
// ****************************************************************
`define PIN_COUNT     32
`define PINS_PER_REG  8
`define SEL_WIDTH     4

// ****************************************************************
// function placement masks
// ****************************************************************
`define GRANT_MASK    16'h4141
`define SHARED_MEMORY_REQUEST_MASK     16'h8282
`define PMEV_MASK     16'h1824
`define WDOG_MASK     16'h0f0f
`define BAUDIN_MASK   16'hc030
`define BAUDOUT_MASK  16'h30c0
`define BURST_MASK    8'h69
`define PCI_PORT_MAP  24'h72c688

`endif

// >>> pin_mux_pkg.sv
package pin_mux_pkg;

	// ****************************************************************
	// select codes
	// ****************************************************************
	typedef enum logic [3:0] {
		SEL_PORT      = 4'h0,
		SEL_DMA       = 4'h1,
		SEL_MEMPM     = 4'h2,
		SEL_XFER_END  = 4'h3,
		SEL_TIMER     = 4'h4,
		SEL_BUS_IND   = 4'h5,
		SEL_INT       = 4'h6,
		SEL_PCI_ARB   = 4'h7,
		SEL_WDOG_BAUD = 4'h9,
		SEL_DEBUG     = 4'hf
	} sel_code_type;

	// ****************************************************************
	// decoded pin functions
	// ****************************************************************
	typedef enum logic [4:0] {
		FN_NONE     = 5'b00000,
		FN_PORT     = 5'b00001,
		FN_DMA_REQ  = 5'b00010,
		FN_DMA_ACK  = 5'b00011,
		FN_MEM_GNT  = 5'b00100,
		FN_MEM_REQ  = 5'b00101,
		FN_PM_EVENT = 5'b00110,
		FN_END_XFER = 5'b00111,
		FN_TMR_EN   = 5'b01000,
		FN_TMR_TC   = 5'b01001,
		FN_BURST    = 5'b01010,
		FN_INIT     = 5'b01011,
		FN_INT      = 5'b01100,
		FN_PCI_GNT  = 5'b01101,
		FN_PCI_REQ  = 5'b01110,
		FN_WD_NMI   = 5'b01111,
		FN_WD_EXP   = 5'b10000,
		FN_BAUD_IN  = 5'b10001,
		FN_BAUD_OUT = 5'b10010,
		FN_DEBUG    = 5'b10011
	} pin_fn_type;

	// ****************************************************************
	// module state
	// ****************************************************************
	typedef struct packed {
		logic [3:0][31:0] sel;
		logic             wrPend;
		logic [1:0]       wrIdx;
		logic [31:0]      rdata;
		logic [31:0]      pinOut;
		logic [31:0]      pinOe;
		logic [31:0]      portIn;
		logic [7:0]       dmaReqN;
		logic             memGrantN;
		logic [7:0]       xferEnd;
		logic [7:0]       tmrEn;
		logic [5:0]       pciReqN;
		logic             baudIn;
	} state_type;

endpackage

// >>> board_pins.sv
`timescale 1ns/1ps

// ****************************************************************
// board devices on the multi-purpose pins
// ****************************************************************
module board_pins (
	// device side
	input  wire logic [31:0] pinDrive,
	input  wire logic [31:0] pinDriveEn,
	// board side
	input  wire logic [31:0] boardValue,
	output logic [31:0]      pinLevel
);
	// the device wins where it drives; the board holds every other line
	assign pinLevel = (pinDrive & pinDriveEn) | (boardValue & ~pinDriveEn);
endmodule

// >>> multi_purpose_pin_mux_test.sv
`timescale 1ns/1ps

module multi_purpose_pin_mux_test;
	// ****************************************************************
	// stimulus and wiring
	// ****************************************************************
	logic             clk;
	logic             sys_rst;
	logic             hsel;
	logic [31:0]      haddr;
	logic [1:0]       htrans;
	logic             hwrite;
	logic [2:0]       hsize;
	logic [31:0]      hwdata;
	logic             hreadyout;
	logic             hresp;
	logic [31:0]      hrdata;
	logic [31:0]      pinLevel;
	logic [31:0]      pinDrive;
	logic [31:0]      pinDriveEn;
	logic [31:0]      boardValue;
	logic [31:0]      portDriveValue;
	logic [31:0]      portDriveEnable;
	logic [31:0]      portSample;
	logic [7:0]       dmaRequestInN;
	logic [7:0]       dmaAcknowledgeOutN;
	logic [7:0]       dmaEndOfTransfer;
	logic             sharedMemoryGrantN;
	logic             sharedMemoryRequestN;
	logic             pmEventN;
	logic [7:0]       timerEnableIn;
	logic [7:0]       timerTerminalCountOut;
	logic             burstIndicationN;
	logic             initActiveIndication;
	logic [3:0]       intOutN;
	logic [5:0]       pciGrantN;
	logic [5:0]       pciRequestN;
	logic             watchdogNmiOutN;
	logic             watchdogExpireOutN;
	logic             baudClockIn;
	logic             baudClockOut;
	logic [31:0]      debugOut;
	logic [3:0][31:0] shadow;
	int               failures;
	int               num_checks;

	multi_purpose_pin_mux i_dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .pinLevel, .pinDrive, .pinDriveEn,
		.portDriveValue, .portDriveEnable, .portSample, .dmaRequestInN, .dmaAcknowledgeOutN,
		.dmaEndOfTransfer, .sharedMemoryGrantN, .sharedMemoryRequestN, .pmEventN, .timerEnableIn,
		.timerTerminalCountOut, .burstIndicationN, .initActiveIndication, .intOutN, .pciGrantN,
		.pciRequestN, .watchdogNmiOutN, .watchdogExpireOutN, .baudClockIn, .baudClockOut, .debugOut);

	board_pins i_board (.pinDrive, .pinDriveEn, .boardValue, .pinLevel);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************************************
	// helpers
	// ****************************************************************
	task report_and_stop;
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// one single transfer of size sz; no wait count is assumed
	task ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd, input logic [2:0] sz,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= addr;
		htrans <= 2'b10;
		hwrite <= wr;
		hsize <= sz;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
	endtask

	// complementary patterns so that every routed source toggles
	task drive_inputs(input bit k);
		logic [31:0] p;
		p = k ? 32'ha5c3_5a3c : 32'h5a3c_a5c3;
		portDriveValue <= p;
		portDriveEnable <= {p[15:0], ~p[31:16]};
		boardValue <= {p[23:0], ~p[31:24]};
		debugOut <= ~p;
		dmaAcknowledgeOutN <= p[7:0];
		timerTerminalCountOut <= p[15:8];
		pciGrantN <= p[21:16];
		intOutN <= p[25:22];
		{sharedMemoryRequestN, pmEventN, burstIndicationN, initActiveIndication} <= p[29:26];
		{watchdogNmiOutN, watchdogExpireOutN, baudClockOut} <= {p[30], p[31], p[0]};
	endtask

	// expected {enable, value} of pin n from its select field
	function automatic logic [1:0] expDrive(input int n);
		logic [3:0] c;
		int         m;
		int         ch;
		c = shadow[n / 8][4 * (n % 8) +: 4];
		m = n % 16;
		ch = m / 2;
		case (c)
			4'h0: return {portDriveEnable[n], portDriveValue[n]};
			4'h1: return (n % 2) ? {1'b1, dmaAcknowledgeOutN[ch]} : 2'b00;
			4'h2: begin
				if (m inside {1, 7, 9, 15}) return {1'b1, sharedMemoryRequestN};
				if (m inside {2, 5, 11, 12}) return {1'b1, pmEventN};
				return 2'b00;
			end
			4'h4: return (n % 2) ? {1'b1, timerTerminalCountOut[ch < 4 ? 3 - ch : 11 - ch]} : 2'b00;
			4'h5: return {1'b1, ((n % 8) inside {0, 3, 5, 6}) ? burstIndicationN : initActiveIndication};
			4'h6: return {1'b1, intOutN[n % 4]};
			4'h7: return (n % 2) ? 2'b00 : {1'b1, pciGrantN[ch < 6 ? ch : 10 - ch]};
			4'h9: begin
				if (m inside {0, 1, 2, 3, 8, 9, 10, 11})
					return {1'b1, (n % 2) ? watchdogExpireOutN : watchdogNmiOutN};
				if (m inside {6, 7, 12, 13}) return {1'b1, baudClockOut};
				return 2'b00;
			end
			4'hf: return {1'b1, debugOut[n]};
			default: return 2'b00;
		endcase
	endfunction

	task check_pins;
		logic [31:0] eEn;
		logic [31:0] eVal;
		logic [31:0] lvl;
		logic [31:0] ePort;
		logic [7:0]  eReq;
		logic [7:0]  eEot;
		logic [7:0]  eTen;
		logic [5:0]  ePci;
		logic        eGnt;
		logic        eBaud;
		logic [1:0]  d;
		int          m;
		int          ch;
		{eReq, eEot, eTen, ePci, eGnt, eBaud, ePort} = {8'hff, 16'h0, 6'h3f, 1'b1, 1'b0, 32'h0};
		for (int n = 0; n < 32; n++) begin
			d = expDrive(n);
			eEn[n] = d[1];
			eVal[n] = d[1] & d[0];
			lvl[n] = d[1] ? d[0] : boardValue[n];
			m = n % 16;
			ch = m / 2;
			case (shadow[n / 8][4 * (n % 8) +: 4])
				4'h0: ePort[n] = lvl[n];
				4'h1: if (n % 2 == 0) eReq[ch] &= lvl[n];
				4'h2: if (m inside {0, 6, 8, 14}) eGnt &= lvl[n];
				4'h3: eEot[7 - ch] |= lvl[n];
				4'h4: if (n % 2 == 0) eTen[ch < 4 ? 3 - ch : 11 - ch] |= lvl[n];
				4'h7: if (n % 2) ePci[ch < 6 ? ch : 10 - ch] &= lvl[n];
				4'h9: if (m inside {4, 5, 14, 15}) eBaud |= lvl[n];
				default: ;
			endcase
		end
		chk(pinDriveEn, eEn);
		chk(pinDrive & pinDriveEn, eVal);
		chk(portSample, ePort);
		chk({dmaRequestInN, dmaEndOfTransfer, timerEnableIn, 8'h0}, {eReq, eEot, eTen, 8'h0});
		chk({24'h0, pciRequestN, sharedMemoryGrantN, baudClockIn}, {24'h0, ePci, eGnt, eBaud});
	endtask

	// every select reads back zero and every pin follows the general port
	task check_cleared;
		logic [31:0] rd;
		shadow = '0;
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, 32'hf000 + 32'(4 * i), 32'h0, 3'h2, rd);
			chk(rd, 32'h0);
		end
		#1;
		check_pins();
	endtask

	task configure(input logic [3:0][31:0] v, input bit k);
		logic [31:0] rd;
		@(posedge clk);
		drive_inputs(k);
		shadow = v;
		for (int i = 0; i < 4; i++) ahb(1'b1, 32'hf000 + 32'(4 * i), v[i], 3'h2, rd);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, 32'hf000 + 32'(4 * i), 32'h0, 3'h2, rd);
			chk(rd, v[i]);
		end
		repeat (2) @(posedge clk);
		#1;
		check_pins();
	endtask

	// ****************************************************************
	// test sequence
	// ****************************************************************
	initial begin
		logic [31:0] rd;
		{failures, num_checks} = {32'sd0, 32'sd0};
		{sys_rst, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 32'h0};
		shadow = '0;
		drive_inputs(1'b0);
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		check_cleared();
		ahb(1'b0, 32'hf010, 32'h0, 3'h2, rd);
		chk(rd, 32'h0);
		// a byte write must not touch the select word
		ahb(1'b1, 32'hf000, 32'hffff_ffff, 3'h0, rd);
		ahb(1'b0, 32'hf000, 32'h0, 3'h2, rd);
		chk(rd, 32'h0);
		for (int c = 0; c < 16; c++)
			for (int k = 0; k < 2; k++)
				configure({4{{8{4'(c)}}}}, k[0]);
		configure({32'h7654_3210, 32'hfedc_ba98, 32'h89ab_cdef, 32'h0123_4567}, 1'b1);
		// a second reset in mid-run must drop every routed function
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		check_cleared();
		report_and_stop();
	end

	// far beyond the just under one thousand cycles the sequence needs
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
endmodule
